// ===== core/mcr_pkg.sv
package mcr_pkg;

  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned SAMP_W = 16;

  // Register offsets.
  localparam logic [6:0] OFS_OFF_XL = 7'h05;
  localparam logic [6:0] OFS_OFF_ZH = 7'h0a;
  localparam logic [6:0] OFS_IDENT  = 7'h0f;
  localparam logic [6:0] OFS_CTRL1  = 7'h20;
  localparam logic [6:0] OFS_CTRL2  = 7'h21;
  localparam logic [6:0] OFS_CTRL3  = 7'h22;
  localparam logic [6:0] OFS_CTRL4  = 7'h23;
  localparam logic [6:0] OFS_OUT_XL = 7'h28;
  localparam logic [6:0] OFS_OUT_ZH = 7'h2d;

  // Identification value is arbitrary.
  localparam logic [7:0] IDENT_DEF = 8'h5a;

  // Reset values and writable-bit masks; reserved bits always hold zero.
  localparam logic [7:0] CTRL1_RST  = 8'h10;
  localparam logic [7:0] CTRL2_RST  = 8'h00;
  localparam logic [7:0] CTRL3_RST  = 8'h03;
  localparam logic [7:0] CTRL4_RST  = 8'h00;
  localparam logic [7:0] OFF_RST    = 8'h00;
  localparam logic [7:0] CTRL1_MASK = 8'hff;
  localparam logic [7:0] CTRL2_MASK = 8'h6c;
  localparam logic [7:0] CTRL3_MASK = 8'ha7;
  localparam logic [7:0] CTRL4_MASK = 8'h0e;

  // Field positions.
  localparam int unsigned B1_TEMP    = 7;
  localparam int unsigned B1_XYP_LO  = 5;
  localparam int unsigned B1_RATE_LO = 2;
  localparam int unsigned B1_FAST    = 1;
  localparam int unsigned B1_SELF    = 0;
  localparam int unsigned B2_RNG_LO  = 5;
  localparam int unsigned B2_REBOOT  = 3;
  localparam int unsigned B2_CLEAR   = 2;
  localparam int unsigned B3_I2C_DIS = 7;
  localparam int unsigned B3_REDUCED = 5;
  localparam int unsigned B3_SPI_RD  = 2;
  localparam int unsigned B3_MODE_LO = 0;
  localparam int unsigned B4_ZP_LO   = 2;
  localparam int unsigned B4_ORDER   = 1;

  localparam logic [2:0] RATE_SLOWEST = 3'h0;
  localparam logic [1:0] MODE_CONT    = 2'h0;
  localparam logic [1:0] MODE_SINGLE  = 2'h1;
  localparam logic [1:0] MODE_DOWN    = 2'h3;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic              spi;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mcr_acc_t;

  typedef struct packed {
    logic [SAMP_W-1:0] x;
    logic [SAMP_W-1:0] y;
    logic [SAMP_W-1:0] z;
  } mcr_samp_t;

  typedef struct packed {
    logic       temp_comp;
    logic [1:0] xy_performance_select;
    logic [2:0] rate_code;
    logic       high_rate_enable;
    logic       selfcheck_enable;
    logic [1:0] range_select;
    logic       min_averaging;
    logic [1:0] z_performance_select;
    logic [1:0] conversion_mode_select;
  } mcr_cfg_t;

endpackage : mcr_pkg

// ===== core/mcr_offset_sub.sv
`timescale 1ns/100ps

module mcr_offset_sub #(
  parameter int unsigned WIDTH = 16
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rstn_i,
  input  wire logic             valid_i,
  input  wire logic [WIDTH-1:0] raw_i,
  input  wire logic [WIDTH-1:0] offset_i,
  output logic      [WIDTH-1:0] corr_o
);

  // Two's complement wraps; no saturation, matching a plain subtractor.
  wire logic [WIDTH-1:0] diff_w = raw_i - offset_i;

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      corr_o <= '0;
    end else if (valid_i) begin
      corr_o <= diff_w;
    end
  end

  property p_offset_sub;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      valid_i |=> corr_o == $past(raw_i) - $past(offset_i);
  endproperty
  a_offset_sub: assert property (p_offset_sub) else $error("corrected sample is not raw minus offset");

endmodule : mcr_offset_sub

// ===== core/mcr_regs.sv
`timescale 1ns/100ps

module mcr_regs #(
  parameter logic [7:0] IDENT = mcr_pkg::IDENT_DEF
) (
  input  wire logic              clk_sys_i,
  input  wire logic              rstn_i,
  input  wire mcr_pkg::mcr_acc_t acc_i,
  output logic                   acc_ack_o,
  output logic [7:0]             acc_rdata_o,
  input  wire logic              sample_valid_i,
  input  wire mcr_pkg::mcr_samp_t sample_i,
  output mcr_pkg::mcr_samp_t     corr_o,
  output logic                   corr_valid_o,
  output mcr_pkg::mcr_cfg_t      cfg_o,
  output logic                   fast_rate_o,
  output logic                   convert_req_o,
  output logic                   reboot_o
);
  import mcr_pkg::*;

  logic [7:0] off_r [6];
  logic [7:0] ctrl1_r;
  logic [7:0] ctrl2_r;
  logic [7:0] ctrl3_r;
  logic [7:0] ctrl4_r;
  logic       reboot_r;
  logic       ack_r;
  logic [7:0] rdata_r;
  logic       cvalid_r;
  logic [7:0] rd_mux;

  // Access acceptance: two-wire blocked while disabled, SPI reads gated.
  wire logic i2c_dis_w  = ctrl3_r[B3_I2C_DIS];
  wire logic spi_rd_w   = ctrl3_r[B3_SPI_RD];
  wire logic spi_ok_w   = acc_i.write | spi_rd_w;
  wire logic port_ok_w  = acc_i.spi ? spi_ok_w : ~i2c_dis_w;
  wire logic go_w       = acc_i.valid & port_ok_w;
  wire logic wr_go_w    = go_w & acc_i.write;
  wire logic rd_go_w    = go_w & ~acc_i.write;
  wire logic wr_ctrl2_w = wr_go_w & (acc_i.addr == OFS_CTRL2);
  wire logic clear_w    = wr_ctrl2_w & acc_i.wdata[B2_CLEAR];
  wire logic boot_w     = wr_ctrl2_w & acc_i.wdata[B2_REBOOT];
  wire logic in_off_w   = (acc_i.addr >= OFS_OFF_XL) && (acc_i.addr <= OFS_OFF_ZH);
  wire logic [2:0] off_idx_w = 3'(acc_i.addr - OFS_OFF_XL);
  wire logic [1:0] mode_w    = ctrl3_r[B3_MODE_LO +: 2];
  wire logic single_done_w   = sample_valid_i && (mode_w == MODE_SINGLE);
  wire logic reduced_w       = ctrl3_r[B3_REDUCED];

  // Offset words assembled from byte pairs, low byte at the lower address.
  wire logic [15:0] off_x_w = {off_r[1], off_r[0]};
  wire logic [15:0] off_y_w = {off_r[3], off_r[2]};
  wire logic [15:0] off_z_w = {off_r[5], off_r[4]};

  function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic upper_addr, input logic msb_first);
    pick_byte = (upper_addr ^ msb_first) ? w[15:8] : w[7:0];
  endfunction : pick_byte

  wire logic byte_order_w = ctrl4_r[B4_ORDER];

  // Corrected words sit in byte pairs from the first output address up; bit 0 of the index, XORed with the CTRL4 byte-order bit, picks the byte.
  wire logic        in_out_w   = (acc_i.addr >= OFS_OUT_XL) && (acc_i.addr <= OFS_OUT_ZH);
  wire logic [2:0]  out_idx_w  = 3'(acc_i.addr - OFS_OUT_XL);
  wire logic [15:0] out_word_w = (out_idx_w[2:1] == 2'h0) ? corr_o.x :
                                 (out_idx_w[2:1] == 2'h1) ? corr_o.y : corr_o.z;

  always_comb begin
    unique case (acc_i.addr)
      OFS_IDENT: rd_mux = IDENT;
      OFS_CTRL1: rd_mux = ctrl1_r;
      OFS_CTRL2: rd_mux = ctrl2_r;
      OFS_CTRL3: rd_mux = ctrl3_r;
      OFS_CTRL4: rd_mux = ctrl4_r;
      default: begin
        if (in_out_w) begin
          rd_mux = pick_byte(out_word_w, out_idx_w[0], byte_order_w);
        end else if (in_off_w) begin
          rd_mux = off_r[off_idx_w];
        end else begin
          rd_mux = 8'h00;
        end
      end
    endcase
  end

  // Offset storage. Config-clear wins over a same-cycle offset write.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i || clear_w) begin
      for (int i = 0; i < 6; i++) begin
        off_r[i] <= OFF_RST;
      end
    end else if (wr_go_w && in_off_w) begin
      off_r[off_idx_w] <= acc_i.wdata;
    end
  end

  // Control registers; reserved bits are masked so they stay zero even if the host misbehaves.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i || clear_w) begin
      ctrl1_r <= CTRL1_RST;
      ctrl2_r <= CTRL2_RST;
      ctrl3_r <= CTRL3_RST;
      ctrl4_r <= CTRL4_RST;
    end else begin
      if (wr_go_w && acc_i.addr == OFS_CTRL1) begin
        ctrl1_r <= acc_i.wdata & CTRL1_MASK;
      end
      if (wr_ctrl2_w) begin
        ctrl2_r <= acc_i.wdata & CTRL2_MASK & ~(8'h01 << B2_REBOOT);
      end
      if (single_done_w) begin
        // The hardware return to power-down wins over a host write in the same cycle.
        ctrl3_r <= (ctrl3_r & ~(8'h03 << B3_MODE_LO)) | (8'(MODE_DOWN) << B3_MODE_LO);
      end else if (wr_go_w && acc_i.addr == OFS_CTRL3) begin
        ctrl3_r <= acc_i.wdata & CTRL3_MASK;
      end
      if (wr_go_w && acc_i.addr == OFS_CTRL4) begin
        ctrl4_r <= acc_i.wdata & CTRL4_MASK;
      end
    end
  end

  // Reboot is a one-cycle request; the bit reads back zero since the CTRL2 write masks it out.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      reboot_r <= 1'b0;
      ack_r    <= 1'b0;
      rdata_r  <= 8'h00;
      cvalid_r <= 1'b0;
    end else begin
      reboot_r <= boot_w;
      ack_r    <= go_w;
      rdata_r  <= rd_go_w ? rd_mux : 8'h00;
      cvalid_r <= sample_valid_i;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_axis
      wire logic [15:0] raw_w = (g == 0) ? sample_i.x : (g == 1) ? sample_i.y : sample_i.z;
      wire logic [15:0] off_w = (g == 0) ? off_x_w : (g == 1) ? off_y_w : off_z_w;
      wire logic [15:0] out_w;
      mcr_offset_sub #(
        .WIDTH (16)
      ) u_sub (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .valid_i   (sample_valid_i),
        .raw_i     (raw_w),
        .offset_i  (off_w),
        .corr_o    (out_w)
      );
    end
  endgenerate

  assign corr_o.x     = g_axis[0].out_w;
  assign corr_o.y     = g_axis[1].out_w;
  assign corr_o.z     = g_axis[2].out_w;
  assign corr_valid_o = cvalid_r;
  assign acc_ack_o    = ack_r;
  assign acc_rdata_o  = rdata_r;
  assign reboot_o     = reboot_r;

  assign cfg_o.temp_comp              = ctrl1_r[B1_TEMP];
  assign cfg_o.xy_performance_select  = ctrl1_r[B1_XYP_LO +: 2];
  assign cfg_o.rate_code              = reduced_w ? RATE_SLOWEST : ctrl1_r[B1_RATE_LO +: 3];
  assign cfg_o.high_rate_enable       = ctrl1_r[B1_FAST];
  assign cfg_o.selfcheck_enable       = ctrl1_r[B1_SELF];
  assign cfg_o.range_select           = ctrl2_r[B2_RNG_LO +: 2];
  assign cfg_o.min_averaging          = reduced_w;
  assign cfg_o.z_performance_select   = ctrl4_r[B4_ZP_LO +: 2];
  assign cfg_o.conversion_mode_select = mode_w;
  assign fast_rate_o   = ctrl1_r[B1_FAST] & ~reduced_w;
  assign convert_req_o = (mode_w == MODE_CONT) || (mode_w == MODE_SINGLE);

  property p_reduced_rate;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      reduced_w |-> cfg_o.rate_code == RATE_SLOWEST && !fast_rate_o && cfg_o.min_averaging;
  endproperty
  a_reduced_rate: assert property (p_reduced_rate) else $error("reduced power did not force slowest rate");

  property p_clear;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      clear_w |=> ctrl1_r == CTRL1_RST && ctrl3_r == CTRL3_RST && off_x_w == 16'h0000 && ctrl2_r == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("config clear did not restore defaults");

  property p_single;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      single_done_w |=> mode_w == MODE_DOWN && !convert_req_o;
  endproperty
  a_single: assert property (p_single) else $error("single conversion did not return to power-down");

  property p_i2c_block;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      acc_i.valid && !acc_i.spi && i2c_dis_w |=> !acc_ack_o && $stable(ctrl1_r);
  endproperty
  a_i2c_block: assert property (p_i2c_block) else $error("two-wire access answered while disabled");

  property p_spi_read;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      acc_i.valid && acc_i.spi && !acc_i.write |=> acc_ack_o == $past(spi_rd_w);
  endproperty
  a_spi_read: assert property (p_spi_read) else $error("SPI read acceptance does not follow read enable");

  property p_order;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      rd_go_w && acc_i.addr == OFS_OUT_XL |=>
        acc_rdata_o == ($past(byte_order_w) ? $past(corr_o.x[15:8]) : $past(corr_o.x[7:0]));
  endproperty
  a_order: assert property (p_order) else $error("byte order at lower address is wrong");

  sequence s_boot_req;
    boot_w ##1 !boot_w;
  endsequence
  sequence s_boot_pulse;
    reboot_o ##1 !reboot_o;
  endsequence
  property p_reboot;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      s_boot_req |-> s_boot_pulse;
  endproperty
  a_reboot: assert property (p_reboot) else $error("reboot request not issued");

  property p_reserved;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      wr_go_w |=> (ctrl2_r & ~CTRL2_MASK) == 8'h00 && (ctrl3_r & ~CTRL3_MASK) == 8'h00 && (ctrl4_r & ~CTRL4_MASK) == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved control bit became nonzero");

  property p_off_map;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      wr_go_w && acc_i.addr == OFS_OFF_XL && !clear_w |=> off_x_w[7:0] == $past(acc_i.wdata);
  endproperty
  a_off_map: assert property (p_off_map) else $error("offset low byte not at its address");

  property p_no_ack;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      !go_w |=> !acc_ack_o && acc_rdata_o == 8'h00;
  endproperty
  a_no_ack: assert property (p_no_ack) else $error("refused or absent access was answered");

  property p_ident;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      rd_go_w && acc_i.addr == OFS_IDENT |=> acc_ack_o && acc_rdata_o == IDENT;
  endproperty
  a_ident: assert property (p_ident) else $error("identification read returned a wrong value");

  property p_ctrl1_fields;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      wr_go_w && acc_i.addr == OFS_CTRL1 |=> cfg_o.temp_comp == $past(acc_i.wdata[B1_TEMP]) &&
        cfg_o.xy_performance_select == $past(acc_i.wdata[B1_XYP_LO +: 2]) &&
        cfg_o.selfcheck_enable == $past(acc_i.wdata[B1_SELF]);
  endproperty
  a_ctrl1_fields: assert property (p_ctrl1_fields) else $error("control fields wrong after write");

  property p_rate_code;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      wr_go_w && acc_i.addr == OFS_CTRL1 && !reduced_w |=> cfg_o.rate_code == $past(acc_i.wdata[B1_RATE_LO +: 3]);
  endproperty
  a_rate_code: assert property (p_rate_code) else $error("rate code did not take the written value");

  property p_fast;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      wr_go_w && acc_i.addr == OFS_CTRL1 && !reduced_w |=> fast_rate_o == $past(acc_i.wdata[B1_FAST]);
  endproperty
  a_fast: assert property (p_fast) else $error("high rate permission does not follow its bit");

  property p_range;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      wr_ctrl2_w && !clear_w |=> cfg_o.range_select == $past(acc_i.wdata[B2_RNG_LO +: 2]);
  endproperty
  a_range: assert property (p_range) else $error("full-scale range did not take the written value");

  property p_mode;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      wr_go_w && acc_i.addr == OFS_CTRL3 && !single_done_w |=>
        mode_w == $past(acc_i.wdata[B3_MODE_LO +: 2]) && convert_req_o == !mode_w[1];
  endproperty
  a_mode: assert property (p_mode) else $error("operating mode or conversion request wrong");

  property p_z_axis;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      wr_go_w && acc_i.addr == OFS_CTRL4 |=> cfg_o.z_performance_select == $past(acc_i.wdata[B4_ZP_LO +: 2]);
  endproperty
  a_z_axis: assert property (p_z_axis) else $error("Z performance field did not take the written value");

  // Deliberately not disabled by reset: it checks what reset itself leaves behind.
  property p_reset_vals;
    @(posedge clk_sys_i)
      !rstn_i |=> ctrl1_r == CTRL1_RST && ctrl2_r == CTRL2_RST && ctrl3_r == CTRL3_RST && ctrl4_r == CTRL4_RST &&
        !acc_ack_o && !reboot_o && !corr_valid_o;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset did not restore the default state");

  property p_corr_valid;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      sample_valid_i |=> corr_valid_o;
  endproperty
  a_corr_valid: assert property (p_corr_valid) else $error("corrected sample not flagged valid");

endmodule : mcr_regs

// ===== bench/mcr_host_model.sv
`timescale 1ns/100ps

module mcr_host_model (
  input  wire logic         clk_sys_i,
  input  wire logic         ack_i,
  input  wire logic [7:0]   rdata_i,
  output mcr_pkg::mcr_acc_t acc_o
);
  import mcr_pkg::*;

  initial acc_o = '0;

  // The host never sets a reserved control bit, whatever the caller asks for.
  function automatic logic [7:0] keep_bits(input logic [6:0] a, input logic [7:0] d);
    return (a == OFS_CTRL2) ? (d & CTRL2_MASK) : (a == OFS_CTRL3) ? (d & CTRL3_MASK) :
           (a == OFS_CTRL4) ? (d & CTRL4_MASK) : d;
  endfunction : keep_bits

  // One request cycle; afterwards the lines show the inverse so a stale value never looks valid.
  task automatic access(input logic wr, input logic spi, input logic [6:0] a, input logic [7:0] d,
                        output logic ok, output logic [7:0] rd);
    @(posedge clk_sys_i);
    acc_o <= '{valid: 1'h1, write: wr, spi: spi, addr: a, wdata: keep_bits(a, d)};
    @(posedge clk_sys_i);
    acc_o <= '{valid: 1'h0, write: ~wr, spi: ~spi, addr: ~a, wdata: ~keep_bits(a, d)};
    #1;
    ok = ack_i;
    rd = rdata_i;
  endtask : access
endmodule : mcr_host_model

// ===== bench/tb_top.sv
`timescale 1ns/100ps

module tb_top;
  import mcr_pkg::*;

  logic        clk_sys_i      = 1'h0;
  logic        rstn_i         = 1'h0;
  logic        sample_valid_i = 1'h0;
  mcr_samp_t   sample_i       = '0;
  mcr_acc_t    acc;
  mcr_samp_t   corr;
  mcr_samp_t   ecorr;
  mcr_cfg_t    cfg;
  logic        ack, ok, reboot, corr_valid, fast_rate, convert_req;
  logic [7:0]  rdata, rd;
  logic [7:0]  ob [6];
  logic [15:0] lfsr       = 16'hb682;
  int          n_errors   = 0;
  int          n_compared = 0;
  int          n_boot     = 0;

  always #50 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (reboot === 1'h1) n_boot++;

  mcr_regs uut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .acc_i(acc), .acc_ack_o(ack), .acc_rdata_o(rdata),
    .sample_valid_i(sample_valid_i), .sample_i(sample_i), .corr_o(corr), .corr_valid_o(corr_valid),
    .cfg_o(cfg), .fast_rate_o(fast_rate), .convert_req_o(convert_req), .reboot_o(reboot));
  mcr_host_model host (.clk_sys_i(clk_sys_i), .ack_i(ack), .rdata_i(rdata), .acc_o(acc));

  function automatic logic [15:0] rnd();
    lfsr = {1'h0, lfsr[15:1]} ^ (lfsr[0] ? 16'hb400 : 16'h0000);
    return lfsr;
  endfunction : rnd

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic rd_reg(input logic spi, input logic [6:0] a, input logic [7:0] exp);
    host.access(1'h0, spi, a, 8'h00, ok, rd);
    check({15'h0, ok}, 16'h0001);
    check({8'h00, rd}, {8'h00, exp});
  endtask : rd_reg

  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    host.access(1'h1, 1'h1, a, d, ok, rd);
    check({15'h0, ok}, 16'h0001);
  endtask : wr_reg

  // Offsets are subtracted with wrap-around, matching the sixteen-bit register width.
  function automatic mcr_samp_t exp_corr(input mcr_samp_t s);
    return '{x: s.x - {ob[1], ob[0]}, y: s.y - {ob[3], ob[2]}, z: s.z - {ob[5], ob[4]}};
  endfunction : exp_corr

  task automatic samp();
    mcr_samp_t s;
    s = {rnd(), rnd(), rnd()};
    ecorr = exp_corr(s);
    @(posedge clk_sys_i);
    sample_valid_i <= 1'h1;
    sample_i       <= s;
    @(posedge clk_sys_i);
    sample_valid_i <= 1'h0;
    sample_i       <= ~s;
    #1;
    check({15'h0, corr_valid}, 16'h0001);
    check(corr.x, ecorr.x);
    check(corr.y, ecorr.y);
    check(corr.z, ecorr.z);
  endtask : samp

  task automatic give_verdict();
    if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  initial begin
    #1000000;
    n_errors++;
    give_verdict();
  end

  initial begin
    int b;
    repeat (6) @(posedge clk_sys_i);
    rstn_i <= 1'h1;
    for (int i = 0; i < 6; i++) rd_reg(1'h0, OFS_OFF_XL + 7'(i), 8'h00);
    rd_reg(1'h0, OFS_IDENT, IDENT_DEF);
    rd_reg(1'h0, OFS_CTRL1, 8'h10);
    rd_reg(1'h0, OFS_CTRL2, 8'h00);
    rd_reg(1'h0, OFS_CTRL3, 8'h03);
    rd_reg(1'h0, OFS_CTRL4, 8'h00);
    check({15'h0, convert_req}, 16'h0000);
    host.access(1'h0, 1'h1, OFS_CTRL1, 8'h00, ok, rd);
    check({15'h0, ok}, 16'h0000);
    wr_reg(OFS_CTRL3, 8'h04);
    rd_reg(1'h1, OFS_CTRL3, 8'h04);
    for (int j = 0; j < 4; j++) begin
      for (int k = 0; k < 6; k++) begin
        ob[k] = (j == 0) ? 8'h80 : 8'(rnd());
        wr_reg(OFS_OFF_XL + 7'(k), ob[k]);
      end
      samp();
    end
    rd_reg(1'h1, OFS_OUT_XL, ecorr.x[7:0]);
    wr_reg(OFS_CTRL4, 8'h0a);
    rd_reg(1'h1, OFS_OUT_XL, ecorr.x[15:8]);
    check({14'h0, cfg.z_performance_select}, 16'h0002);
    for (int j = 0; j < 4; j++) begin
      b = (j == 0) ? 8'hff : rnd();
      wr_reg(OFS_CTRL1, 8'(b));
      rd_reg(1'h1, OFS_CTRL1, 8'(b));
      check({8'h00, cfg.temp_comp, cfg.xy_performance_select, cfg.rate_code, cfg.high_rate_enable,
             cfg.selfcheck_enable}, 16'(b & 255));
      check({15'h0, fast_rate}, 16'(b[1]));
    end
    wr_reg(OFS_CTRL1, 8'hff);
    wr_reg(OFS_CTRL3, 8'h24);
    check({11'h0, cfg.rate_code, cfg.min_averaging, fast_rate}, 16'h0002);
    wr_reg(OFS_CTRL3, 8'h04);
    check({11'h0, cfg.rate_code, cfg.min_averaging, fast_rate}, 16'h001d);
    for (int c = 0; c < 4; c++) begin
      wr_reg(OFS_CTRL2, 8'(c << 5));
      rd_reg(1'h1, OFS_CTRL2, 8'(c << 5));
      check({14'h0, cfg.range_select}, 16'(c));
    end
    b = n_boot;
    wr_reg(OFS_CTRL2, 8'h08);
    rd_reg(1'h1, OFS_CTRL2, 8'h00);
    check(16'(n_boot), 16'(b + 1));
    for (int m = 0; m < 4; m++) begin
      wr_reg(OFS_CTRL3, 8'h04 | 8'(m));
      check({13'h0, cfg.conversion_mode_select, convert_req}, 16'((m << 1) | (m < 2)));
    end
    wr_reg(OFS_CTRL3, 8'h05);
    samp();
    rd_reg(1'h1, OFS_CTRL3, 8'h07);
    wr_reg(OFS_CTRL3, 8'h84);
    host.access(1'h0, 1'h0, OFS_CTRL3, 8'h00, ok, rd);
    check({15'h0, ok}, 16'h0000);
    rd_reg(1'h1, OFS_CTRL3, 8'h84);
    wr_reg(OFS_CTRL2, 8'h04);
    rd_reg(1'h0, OFS_CTRL3, 8'h03);
    rd_reg(1'h0, OFS_CTRL1, 8'h10);
    rd_reg(1'h0, OFS_OFF_ZH, 8'h00);
    rd_reg(1'h0, 7'h01, 8'h00);
    wr_reg(OFS_IDENT, 8'h00);
    rd_reg(1'h0, OFS_IDENT, IDENT_DEF);
    give_verdict();
  end
endmodule : tb_top
